//--- rtl/sws_pkg.sv
// constants, types and register map of the slave state and watchdog block
// assumes a 10 MHz system clock and a 32-bit apb register bus
package sws_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 100; // system clock period
  localparam int BASE_PERIOD_NS = 40; // watchdog base clock, 25 MHz
  localparam int ACC_UNIT_NS = 20; // common unit of both periods
  localparam int ACC_STEP = CLK_PERIOD_NS / ACC_UNIT_NS; // per clock
  localparam int ACC_PER_BASE = BASE_PERIOD_NS / ACC_UNIT_NS; // per base
  localparam logic [15:0] MULT_OFFSET = 16'h0002; // tick = mult + 2 bases

  // reset values
  localparam logic [15:0] MULT_RESET = 16'h09c2; // 2498 -> 100 us tick
  localparam int WD_TICK_US = 100; // tick with reset multiplier
  localparam int WD_TIMEOUT_MS = 100; // default timeout of both watchdogs
  localparam logic [15:0] WD_TIME_RESET =
    16'((WD_TIMEOUT_MS * 1000) / WD_TICK_US); // 1000 ticks
  localparam logic [1:0] CTRL_RESET = 2'h3; // both watchdogs enabled

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MULT = 8'h04;
  localparam logic [7:0] OFS_SM_TIME = 8'h08;
  localparam logic [7:0] OFS_PDI_TIME = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_OUT_DATA = 8'h18;
  localparam logic [7:0] OFS_IN_DATA = 8'h1c;
  localparam logic [7:0] OFS_DC_LO = 8'h20;
  localparam logic [7:0] OFS_DC_HI = 8'h24;
  localparam logic [7:0] OFS_CFG_OK = 8'h28;
  localparam logic [7:0] OFS_MBX = 8'h2c;

  // field positions
  localparam int CTRL_SM_EN = 0;
  localparam int CTRL_PDI_EN = 1;
  localparam int CFG_MBX_OK = 0; // mailbox channels set up
  localparam int CFG_PD_OK = 1; // process data channels set up
  localparam int CFG_DC_OK = 2; // distributed clock settings valid
  localparam int STAT_SM_EXP = 0;
  localparam int STAT_PDI_EXP = 1;
  localparam int STAT_TR_ERR = 2;
  localparam logic [3:0] MBX_TYPE_FILE = 4'h4; // file access type

  // state codes as software writes and reads them
  localparam logic [3:0] CODE_INIT = 4'h1;
  localparam logic [3:0] CODE_PREOP = 4'h2;
  localparam logic [3:0] CODE_BOOT = 4'h3;
  localparam logic [3:0] CODE_SAFEOP = 4'h4;
  localparam logic [3:0] CODE_OP = 4'h8;

  // slave states, one-hot
  typedef enum logic [4:0] {
    ST_INIT = 5'b00001,
    ST_PREOP = 5'b00010,
    ST_SAFEOP = 5'b00100,
    ST_OP = 5'b01000,
    ST_BOOT = 5'b10000
  } sws_state_type;

  // configuration of one watchdog
  typedef struct packed {
    logic en; // monitoring switched on
    logic [15:0] time_ticks; // timeout in watchdog ticks
  } sws_wd_cfg_type;

endpackage

//--- rtl/sws_wdog.sv
// one watchdog timer counting shared ticks up to its own timeout
// assumes tick_i and kick_i are single-cycle pulses on clk_i
`timescale 1ns/1ps
module sws_wdog
  import sws_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // synchronised reset, active low
  input wire logic tick_i, // shared watchdog tick
  input wire logic kick_i, // successful access, restarts count
  input wire sws_wd_cfg_type cfg_i, // enable and timeout
  output logic expired_o // watchdog has run out
);

  logic [15:0] count_q; // ticks since last restart
  logic active; // monitoring really on

  // a zero timeout switches the watchdog off entirely
  assign active = cfg_i.en && (cfg_i.time_ticks != 16'h0000);

  // tick counter, restarted by a successful access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= 16'h0000;
    end else if (!active || kick_i) begin
      count_q <= 16'h0000;
    end else if (tick_i && count_q != 16'hffff) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // expiry set once when the count reaches the timeout; it beats a kick
  // in that cycle, but a later kick always clears the flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      expired_o <= 1'b0;
    end else if (!active) begin
      expired_o <= 1'b0;
    end else if (!expired_o && tick_i &&
                 count_q + 16'h0001 >= cfg_i.time_ticks) begin
      expired_o <= 1'b1;
    end else if (kick_i) begin
      expired_o <= 1'b0;
    end
  end

endmodule

//--- rtl/sws_top.sv
// slave state machine, two watchdogs and distributed clock behind apb
// assumes din_i are asynchronous pins and pdi_access_i is on clk_i
//
// Summary of operation
// - process data access restarts sync-manager watchdog
// - its expiry clears outputs, state kept
// - local interface silence triggers second watchdog
// - both watchdogs default to 100 ms
// - tick is (multiplier+2) 40 ns periods, shared
// - multiplier resets to 2498, 100 us
// - each watchdog has own tick count
// - sync-manager count resets to 1000
// - counts 0..65535, multiplier 1..65535 accepted
// - zero count disables the watchdog entirely
// - start in Init, no mailbox or data
// - Init to Pre-Op checks mailbox setup
// - Pre-Op allows mailbox, not process data
// - Pre-Op to Safe-Op checks setup, copies inputs
// - Safe-Op exchanges data, outputs held safe
// - watchdog off lets outputs switch in Safe-Op
// - Op drives master data onto outputs
// - Boot only from Init, file mailbox only
// - 64-bit nanosecond clock, optionally 32 bits
`timescale 1ns/1ps
module sws_top
  import sws_pkg::*;
#(
  parameter int DATA_W = 8, // number of digital channels
  parameter int DC_W = 64 // distributed clock width, 64 or 32
) (
  input wire logic clk_i, // system clock, 10 MHz
  input wire logic reset_n_i, // asynchronous reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb access phase
  input wire logic pwrite_i, // apb direction, high for write
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error, refused access
  input wire logic pdi_access_i, // local application access pulse
  input wire logic [DATA_W-1:0] din_i, // physical inputs, async
  output logic [DATA_W-1:0] dout_o, // physical outputs
  output logic [31:0] mbx_data_o, // accepted mailbox word
  output logic mbx_valid_o, // mailbox word pulse
  output logic [4:0] state_o, // current slave state, one-hot
  output logic sm_expired_o, // sync-manager watchdog expired
  output logic pdi_expired_o // local interface watchdog expired
);

  // map a written state code onto a state; unknown codes give zero
  function automatic logic [4:0] code_to_state(input logic [3:0] code);
    if (code == CODE_INIT) return ST_INIT;
    else if (code == CODE_PREOP) return ST_PREOP;
    else if (code == CODE_BOOT) return ST_BOOT;
    else if (code == CODE_SAFEOP) return ST_SAFEOP;
    else if (code == CODE_OP) return ST_OP;
    else return 5'b00000;
  endfunction

  // map a state onto its readable code
  function automatic logic [3:0] state_to_code(input sws_state_type s);
    case (s)
      ST_PREOP: return CODE_PREOP;
      ST_SAFEOP: return CODE_SAFEOP;
      ST_OP: return CODE_OP;
      ST_BOOT: return CODE_BOOT;
      default: return CODE_INIT;
    endcase
  endfunction

  logic [1:0] rst_sync_q; // reset release synchroniser
  logic rst_n; // synchronised reset used everywhere
  logic [DATA_W-1:0] din_meta_q; // first input synchroniser stage
  logic [DATA_W-1:0] din_sync_q; // second input synchroniser stage
  logic [1:0] ctrl_q; // watchdog enables
  logic [15:0] mult_q; // shared tick multiplier
  logic [15:0] sm_time_q; // sync-manager timeout in ticks
  logic [15:0] pdi_time_q; // local interface timeout in ticks
  logic [2:0] cfg_ok_q; // setup indications from the master
  logic tr_err_q; // last requested transition refused
  logic [DATA_W-1:0] out_data_q; // output image from the master
  logic [DATA_W-1:0] in_data_q; // input image for the master
  logic [63:0] dc_q; // distributed clock, ns
  logic [17:0] acc_q; // tick accumulator in 20 ns units
  logic tick_q; // shared watchdog tick pulse
  sws_state_type state_q; // slave state
  sws_wd_cfg_type sm_cfg; // sync-manager watchdog setup
  sws_wd_cfg_type pdi_cfg; // local interface watchdog setup
  logic sm_exp; // sync-manager watchdog output
  logic pdi_exp; // local interface watchdog output
  logic apb_acc; // access phase in its last cycle
  logic wr; // write takes effect this edge
  logic rd_setup; // read data prepared this edge
  logic pd_ok; // process data allowed in this state
  logic mbx_ok; // mailbox allowed for this word
  logic refuse; // access is refused
  logic sm_kick; // successful process data access
  logic sm_off; // sync-manager monitoring deactivated
  logic [17:0] acc_lim; // accumulator units per tick
  logic [4:0] req_st; // requested state from a write
  logic [63:0] dc_next; // clock after this cycle
  logic [31:0] rdata; // read mux result

  // reset is taken asynchronously and released through two flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // input pins pass two flops before use
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      din_meta_q <= '0;
      din_sync_q <= '0;
    end else begin
      din_meta_q <= din_i;
      din_sync_q <= din_meta_q;
    end
  end

  // apb phases: one wait state, action on the edge with pready high
  assign apb_acc = psel_i && penable_i && pready_o;
  assign wr = apb_acc && pwrite_i;
  assign rd_setup = psel_i && penable_i && !pready_o;
  assign pd_ok = (state_q == ST_SAFEOP) || (state_q == ST_OP);
  assign req_st = code_to_state(pwdata_i[3:0]);

  // mailbox: refused in init, boot passes only file access
  always_comb begin
    if (state_q == ST_INIT) begin
      mbx_ok = 1'b0;
    end else if (state_q == ST_BOOT) begin
      mbx_ok = (pwdata_i[3:0] == MBX_TYPE_FILE);
    end else begin
      mbx_ok = 1'b1;
    end
  end

  // refused: process data outside safe-op and op, bad mailbox
  always_comb begin
    if (paddr_i == OFS_OUT_DATA || paddr_i == OFS_IN_DATA) begin
      refuse = !pd_ok;
    end else if (paddr_i == OFS_MBX) begin
      refuse = !pwrite_i || !mbx_ok;
    end else if (paddr_i[1:0] != 2'b00 || paddr_i > OFS_MBX) begin
      refuse = 1'b1; // unmapped address
    end else begin
      refuse = 1'b0;
    end
  end

  // only a successful process data access restarts the watchdog
  assign sm_kick = apb_acc && pd_ok &&
    ((pwrite_i && paddr_i == OFS_OUT_DATA) ||
     (!pwrite_i && paddr_i == OFS_IN_DATA));

  // apb handshake and error answer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= rd_setup;
      pslverr_o <= rd_setup && refuse;
    end
  end

  // read mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (paddr_i == OFS_CTRL) begin
      rdata = {30'h0, ctrl_q};
    end else if (paddr_i == OFS_MULT) begin
      rdata = {16'h0000, mult_q};
    end else if (paddr_i == OFS_SM_TIME) begin
      rdata = {16'h0000, sm_time_q};
    end else if (paddr_i == OFS_PDI_TIME) begin
      rdata = {16'h0000, pdi_time_q};
    end else if (paddr_i == OFS_STATE) begin
      rdata = {28'h0, state_to_code(state_q)};
    end else if (paddr_i == OFS_STATUS) begin
      rdata = {29'h0, tr_err_q, pdi_exp, sm_exp};
    end else if (paddr_i == OFS_OUT_DATA) begin
      rdata[DATA_W-1:0] = out_data_q;
    end else if (paddr_i == OFS_IN_DATA) begin
      rdata[DATA_W-1:0] = in_data_q;
    end else if (paddr_i == OFS_DC_LO) begin
      rdata = dc_q[31:0];
    end else if (paddr_i == OFS_DC_HI) begin
      rdata = dc_q[63:32];
    end else if (paddr_i == OFS_CFG_OK) begin
      rdata = {29'h0, cfg_ok_q};
    end
  end

  // read data registered on the same edge that raises pready
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup && !pwrite_i && !refuse) begin
      prdata_o <= rdata;
    end else if (rd_setup) begin
      prdata_o <= 32'h0000_0000;
    end
  end

  // watchdog setup registers; a zero multiplier write is ignored
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      mult_q <= MULT_RESET;
      sm_time_q <= WD_TIME_RESET;
      pdi_time_q <= WD_TIME_RESET;
      cfg_ok_q <= 3'h0;
    end else if (wr) begin
      if (paddr_i == OFS_CTRL) begin
        ctrl_q <= pwdata_i[1:0];
      end else if (paddr_i == OFS_MULT && pwdata_i[15:0] != 16'h0000) begin
        mult_q <= pwdata_i[15:0];
      end else if (paddr_i == OFS_SM_TIME) begin
        sm_time_q <= pwdata_i[15:0];
      end else if (paddr_i == OFS_PDI_TIME) begin
        pdi_time_q <= pwdata_i[15:0];
      end else if (paddr_i == OFS_CFG_OK) begin
        cfg_ok_q <= pwdata_i[2:0];
      end
    end
  end

  // shared tick: 100 ns per clock against (mult + 2) * 40 ns
  assign acc_lim = 18'(ACC_PER_BASE) * ({2'b00, mult_q} + 18'(MULT_OFFSET));
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 18'h00000;
      tick_q <= 1'b0;
    end else if (acc_q + 18'(ACC_STEP) >= acc_lim) begin
      acc_q <= acc_q + 18'(ACC_STEP) - acc_lim;
      tick_q <= 1'b1;
    end else begin
      acc_q <= acc_q + 18'(ACC_STEP);
      tick_q <= 1'b0;
    end
  end

  // the two watchdogs share the tick, each has its own count
  assign sm_cfg = '{en: ctrl_q[CTRL_SM_EN], time_ticks: sm_time_q};
  assign pdi_cfg = '{en: ctrl_q[CTRL_PDI_EN], time_ticks: pdi_time_q};
  assign sm_off = !sm_cfg.en || (sm_time_q == 16'h0000);

  sws_wdog u_sm_wdog (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .tick_i(tick_q),
    .kick_i(sm_kick),
    .cfg_i(sm_cfg),
    .expired_o(sm_exp)
  );

  // local side watchdog restarted by any application access
  sws_wdog u_pdi_wdog (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .tick_i(tick_q),
    .kick_i(pdi_access_i),
    .cfg_i(pdi_cfg),
    .expired_o(pdi_exp)
  );

  // slave state machine; expiry never changes the state
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_INIT;
      tr_err_q <= 1'b0;
    end else if (wr && paddr_i == OFS_STATE) begin
      tr_err_q <= 1'b1;
      case (state_q)
        ST_INIT: begin
          if (req_st == ST_INIT) begin
            tr_err_q <= 1'b0;
          end else if (req_st == ST_PREOP && cfg_ok_q[CFG_MBX_OK]) begin
            state_q <= ST_PREOP;
            tr_err_q <= 1'b0;
          end else if (req_st == ST_BOOT) begin
            state_q <= ST_BOOT;
            tr_err_q <= 1'b0;
          end
        end
        ST_PREOP: begin
          if (req_st == ST_INIT || req_st == ST_PREOP) begin
            state_q <= sws_state_type'(req_st);
            tr_err_q <= 1'b0;
          end else if (req_st == ST_SAFEOP && cfg_ok_q[CFG_PD_OK] &&
                       cfg_ok_q[CFG_DC_OK]) begin
            state_q <= ST_SAFEOP;
            tr_err_q <= 1'b0;
          end
        end
        ST_SAFEOP, ST_OP: begin
          if (req_st != 5'b00000 && req_st != ST_BOOT) begin
            state_q <= sws_state_type'(req_st);
            tr_err_q <= 1'b0;
          end
        end
        ST_BOOT: begin
          if (req_st == ST_INIT || req_st == ST_BOOT) begin
            state_q <= sws_state_type'(req_st);
            tr_err_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_INIT;
        end
      endcase
    end
  end

  // output image written by the master while process data runs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_data_q <= '0;
    end else if (wr && paddr_i == OFS_OUT_DATA && pd_ok) begin
      out_data_q <= pwdata_i[DATA_W-1:0];
    end
  end

  // inputs copied on safe-op entry and cyclically in safe-op and op
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      in_data_q <= '0;
    end else if (pd_ok) begin
      in_data_q <= din_sync_q;
    end else if (wr && paddr_i == OFS_STATE && req_st == ST_SAFEOP) begin
      in_data_q <= din_sync_q;
    end
  end

  // physical outputs: safe unless op, or safe-op with watchdog off
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dout_o <= '0;
    end else if (sm_exp) begin
      dout_o <= '0;
    end else if (state_q == ST_OP) begin
      dout_o <= out_data_q;
    end else if (state_q == ST_SAFEOP && sm_off) begin
      dout_o <= out_data_q;
    end else begin
      dout_o <= '0;
    end
  end

  // mailbox word hand-off to the local side
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mbx_data_o <= 32'h0000_0000;
      mbx_valid_o <= 1'b0;
    end else begin
      mbx_valid_o <= wr && paddr_i == OFS_MBX && mbx_ok;
      if (wr && paddr_i == OFS_MBX && mbx_ok) begin
        mbx_data_o <= pwdata_i;
      end
    end
  end

  // distributed clock in ns; the master may set it to synchronise
  always_comb begin
    dc_next = dc_q + 64'(CLK_PERIOD_NS);
    if (wr && paddr_i == OFS_DC_LO) begin
      dc_next[31:0] = pwdata_i;
    end
    if (wr && paddr_i == OFS_DC_HI) begin
      dc_next[63:32] = pwdata_i;
    end
    if (DC_W == 32) begin
      dc_next[63:32] = 32'h0000_0000;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dc_q <= 64'h0000_0000_0000_0000;
    end else begin
      dc_q <= dc_next;
    end
  end

  // status outputs straight from flops
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_o <= ST_INIT;
      sm_expired_o <= 1'b0;
      pdi_expired_o <= 1'b0;
    end else begin
      state_o <= state_q;
      sm_expired_o <= sm_exp;
      pdi_expired_o <= pdi_exp;
    end
  end

endmodule

//--- tb/sws_apb_mst.sv
// bus master model driving the apb slave port of the block
// assumes each transfer is started right after a rising clock edge
`timescale 1ns/1ps
module sws_apb_mst (
  input wire logic clk_i, // system clock
  input wire logic pready_i, // slave ready
  input wire logic [31:0] prdata_i, // slave read data
  input wire logic pslverr_i, // slave error
  output logic psel_o, // select
  output logic penable_o, // access phase
  output logic pwrite_o, // high for write
  output logic [7:0] paddr_o, // byte address
  output logic [31:0] pwdata_o // write data
);
  // bus idle from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end

  // setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    er = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

//--- tb/sws_top_chk.sv
// port checker of the slave state and watchdog block
// assumes it is bound onto sws_top and sees only its ports
`timescale 1ns/1ps
module sws_top_chk
  import sws_pkg::*;
#(
  parameter int DATA_W = 8, // digital channels
  parameter int DC_W = 64 // clock width
) (
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb access phase
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb address
  input wire logic [31:0] pwdata_i, // apb write data
  input wire logic [31:0] prdata_o, // apb read data
  input wire logic pready_o, // apb ready
  input wire logic pslverr_o, // apb error
  input wire logic pdi_access_i, // local access pulse
  input wire logic [DATA_W-1:0] din_i, // physical inputs
  input wire logic [DATA_W-1:0] dout_o, // physical outputs
  input wire logic [31:0] mbx_data_o, // mailbox word
  input wire logic mbx_valid_o, // mailbox pulse
  input wire logic [4:0] state_o, // one-hot state
  input wire logic sm_expired_o, // sync-manager expiry
  input wire logic pdi_expired_o // local watchdog expiry
);
  logic acc_done; // completed bus access this cycle
  logic wr_done; // completed bus write this cycle
  assign acc_done = psel_i & penable_i & pready_o;
  assign wr_done = acc_done & pwrite_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_sm_kick: assert property (
    $fell(sm_expired_o) |-> $past(acc_done, 2) || $past(wr_done, 3))
    else $error("sync flag fell without a bus access");
  a_out_cleared: assert property (
    sm_expired_o |-> dout_o == '0)
    else $error("outputs not cleared on expiry");
  a_state_by_bus: assert property (
    $changed(state_o) |-> $past(wr_done, 2))
    else $error("state moved without a bus write");
  a_pdi_clear: assert property (
    $fell(pdi_expired_o) |-> $past(pdi_access_i, 2))
    else $error("local flag fell without an access");
  a_pd_blocked: assert property (
    state_o inside {ST_INIT, ST_PREOP, ST_BOOT} |-> dout_o == '0)
    else $error("outputs driven outside data states");
  a_mbx_init: assert property (
    mbx_valid_o |-> state_o != ST_INIT)
    else $error("mailbox accepted in init");
  a_mbx_boot: assert property (
    mbx_valid_o && state_o == ST_BOOT |-> mbx_data_o[3:0] == MBX_TYPE_FILE)
    else $error("non-file mailbox accepted in boot");
  a_boot_entry: assert property (
    $changed(state_o) && state_o == ST_BOOT |-> $past(state_o) == ST_INIT)
    else $error("boot entered from wrong state");
  a_safeop_entry: assert property (
    $changed(state_o) && state_o == ST_SAFEOP |->
      $past(state_o) inside {ST_PREOP, ST_OP})
    else $error("safe state entered from wrong state");
  a_op_entry: assert property (
    $changed(state_o) && state_o == ST_OP |-> $past(state_o) == ST_SAFEOP)
    else $error("run state entered from wrong state");
endmodule

bind sws_top sws_top_chk #(.DATA_W(DATA_W), .DC_W(DC_W)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .pdi_access_i(pdi_access_i), .din_i(din_i),
  .dout_o(dout_o), .mbx_data_o(mbx_data_o), .mbx_valid_o(mbx_valid_o),
  .state_o(state_o), .sm_expired_o(sm_expired_o),
  .pdi_expired_o(pdi_expired_o));

//--- tb/test_slave_state_and_watchdog.sv
// self-checking bench of the slave state and watchdog block
// assumes the master model drives apb right after rising edges
`timescale 1ns/1ps
module test_slave_state_and_watchdog;
  import sws_pkg::*;
  `define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin \
    error_cnt++; $display("BAD %s exp %h got %h", n, x, g); end end

  logic clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pdi_access_i;
  logic [7:0] paddr_i, din_i, dout_o;
  logic [31:0] pwdata_i, prdata_o, mbx_data_o, rd, d1;
  logic pready_o, pslverr_o, mbx_valid_o, sm_expired_o, pdi_expired_o, er;
  logic [4:0] state_o;
  int error_cnt = 0;
  int tests_run = 0;
  typedef struct {logic [7:0] a; logic [31:0] x; logic e;} sws_row_type;
  // reset reads: address, expected word, expected error
  sws_row_type rows [10] = '{'{OFS_CTRL, 32'(CTRL_RESET), 1'b0},
    '{OFS_MULT, 32'(MULT_RESET), 1'b0},
    '{OFS_SM_TIME, 32'h3e8, 1'b0},
    '{OFS_PDI_TIME, 32'h3e8, 1'b0},
    '{OFS_STATE, 32'(CODE_INIT), 1'b0},
    '{OFS_STATUS, 32'h0, 1'b0}, '{OFS_OUT_DATA, 32'h0, 1'b1},
    '{OFS_MBX, 32'h0, 1'b1}, '{8'h30, 32'h0, 1'b1}, '{8'h02, 32'h0, 1'b1}};

  sws_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pdi_access_i(pdi_access_i), .din_i(din_i),
    .dout_o(dout_o), .mbx_data_o(mbx_data_o), .mbx_valid_o(mbx_valid_o),
    .state_o(state_o), .sm_expired_o(sm_expired_o),
    .pdi_expired_o(pdi_expired_o));
  sws_apb_mst mst (.clk_i(clk_i), .pready_i(pready_o), .prdata_i(prdata_o),
    .pslverr_i(pslverr_o), .psel_o(psel_i), .penable_o(penable_i),
    .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one bus access with masked read check and error check
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] m, input logic [31:0] x,
    input logic e);
    @(posedge clk_i);
    mst.xfer(w, a, d, rd, er);
    `CHK("pslverr", e, er)
    `CHK("prdata", x, rd & m)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input e);
    acc(1'b1, a, d, 32'h0, 32'h0, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x, input e);
    acc(1'b0, a, 32'h0, m, x, e);
  endtask
  // wait whole cycles, then let the edge's updates land
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one-cycle local application access
  task automatic pulse();
    @(posedge clk_i);
    pdi_access_i <= 1'b1;
    @(posedge clk_i);
    pdi_access_i <= 1'b0;
  endtask

  // hang guard
  initial begin
    #500000;
    error_cnt++;
    conclude();
  end

  initial begin
    reset_n_i = 1'b0;
    pdi_access_i = 1'b0;
    din_i = 8'h3c;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wt(3);
    foreach (rows[i]) rdc(rows[i].a, 32'hffffffff, rows[i].x, rows[i].e);
    wr(OFS_MBX, 32'h4, 1'b1);
    wr(OFS_STATE, 32'(CODE_BOOT), 1'b0);
    wt(2);
    `CHK("state", ST_BOOT, state_o)
    wr(OFS_MBX, 32'h2, 1'b1);
    wr(OFS_MBX, 32'h4, 1'b0);
    wt(2);
    `CHK("mbx", 32'h4, mbx_data_o)
    wr(OFS_STATE, 32'(CODE_INIT), 1'b0);
    wr(OFS_STATE, 32'(CODE_PREOP), 1'b0);
    rdc(OFS_STATUS, 32'h4, 32'h4, 1'b0);
    wr(OFS_CFG_OK, 32'h1, 1'b0);
    wr(OFS_STATE, 32'(CODE_PREOP), 1'b0);
    rdc(OFS_STATUS, 32'h4, 32'h0, 1'b0);
    wr(OFS_STATE, 32'(CODE_BOOT), 1'b0);
    rdc(OFS_STATE, 32'hf, 32'(CODE_PREOP), 1'b0);
    wr(OFS_MBX, 32'h11, 1'b0);
    rdc(OFS_OUT_DATA, 32'h0, 32'h0, 1'b1);
    wr(OFS_MULT, 32'h0, 1'b0);
    rdc(OFS_MULT, 32'hffff, 32'(MULT_RESET), 1'b0);
    wr(OFS_MULT, 32'h1, 1'b0);
    wr(OFS_SM_TIME, 32'hffff, 1'b0);
    rdc(OFS_SM_TIME, 32'hffff, 32'hffff, 1'b0);
    wr(OFS_SM_TIME, 32'h14, 1'b0);
    wr(OFS_PDI_TIME, 32'h30, 1'b0);
    wr(OFS_CFG_OK, 32'h7, 1'b0);
    wr(OFS_STATE, 32'(CODE_SAFEOP), 1'b0);
    wt(1);
    `CHK("state", ST_SAFEOP, state_o)
    rdc(OFS_IN_DATA, 32'hff, 32'h3c, 1'b0);
    din_i <= 8'hc3;
    wt(4);
    rdc(OFS_IN_DATA, 32'hff, 32'hc3, 1'b0);
    wr(OFS_OUT_DATA, 32'ha5, 1'b0);
    wt(3);
    `CHK("dout", 8'h00, dout_o)
    wr(OFS_STATE, 32'(CODE_OP), 1'b0);
    wt(3);
    `CHK("dout", 8'ha5, dout_o)
    wt(40);
    `CHK("sm flag", 1'b1, sm_expired_o)
    `CHK("dout", 8'h00, dout_o)
    `CHK("state", ST_OP, state_o)
    rdc(OFS_STATUS, 32'h1, 32'h1, 1'b0);
    wr(OFS_OUT_DATA, 32'h5a, 1'b0);
    wt(3);
    `CHK("sm flag", 1'b0, sm_expired_o)
    `CHK("dout", 8'h5a, dout_o)
    rdc(OFS_DC_LO, 32'h0, 32'h0, 1'b0);
    d1 = rd;
    rdc(OFS_DC_LO, 32'h0, 32'h0, 1'b0);
    `CHK("dc step", 32'(4 * CLK_PERIOD_NS), rd - d1)
    wr(OFS_DC_LO, 32'h1000, 1'b0);
    rdc(OFS_DC_LO, 32'hffffffff, 32'h10c8, 1'b0);
    pulse();
    wt(20);
    `CHK("pdi flag", 1'b0, pdi_expired_o)
    wt(60);
    `CHK("pdi flag", 1'b1, pdi_expired_o)
    rdc(OFS_STATUS, 32'h2, 32'h2, 1'b0);
    pulse();
    wt(3);
    `CHK("pdi flag", 1'b0, pdi_expired_o)
    wr(OFS_STATE, 32'(CODE_PREOP), 1'b0);
    wt(2);
    `CHK("dout", 8'h00, dout_o)
    wr(OFS_SM_TIME, 32'h0, 1'b0);
    wr(OFS_STATE, 32'(CODE_SAFEOP), 1'b0);
    wr(OFS_OUT_DATA, 32'h5a, 1'b0);
    wt(40);
    `CHK("dout", 8'h5a, dout_o)
    `CHK("sm flag", 1'b0, sm_expired_o)
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    wt(1);
    `CHK("state", ST_INIT, state_o)
    `CHK("dout", 8'h00, dout_o)
    reset_n_i <= 1'b1;
    wt(3);
    conclude();
  end
endmodule
